// ==== include/shock_fifo_pkg.sv ====
`default_nettype none
package shock_fifo_pkg;
    // clock and timing
    localparam int CLK_MHZ           = 125;
    localparam int RESET_HOLD_CYCLES = 4;
    localparam int WORD_CLK_DIV      = 384;
    localparam int BIT_CLK_DIV       = 8;
    localparam int SUBCODE_WORDS     = 588;
    localparam int INIT_WAIT_US      = 200;
    localparam int INIT_WAIT_CYCLES  = INIT_WAIT_US * CLK_MHZ;
    localparam logic [3:0] INIT_REFRESH_CYCLES = 4'h8;

    // audio path and dram geometry
    localparam int AUDIO_W    = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int PTR_W      = 20;
    localparam int ADDR_W     = 10;
    localparam int ROW_LSB    = 10;
    localparam int NIBBLE_W   = 4;
    localparam logic [19:0] SMALL_MASK   = 20'h3ffff;
    localparam logic [19:0] LARGE_MASK   = 20'hfffff;
    localparam logic [19:0] WORD_NIBBLES = 20'h00004;
    localparam int SMALL_LEVEL_MSB = 17;
    localparam int LARGE_LEVEL_MSB = 19;

    // command register
    localparam int CMD_FLUSH   = 7;
    localparam int CMD_BYPASS  = 6;
    localparam int CMD_ECHO    = 5;
    localparam int CMD_JMP_BZ  = 4;
    localparam int CMD_OTD_P   = 3;
    localparam int CMD_ROT_SD  = 2;
    localparam int CMD_UC_SD   = 1;
    localparam int CMD_POS_FB  = 0;
    localparam logic [7:0] CMD_RESET    = 8'h40;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    typedef struct packed {
        logic levelMsb;
        logic levelNextBit;
        logic framingError;
        logic newSubcodeFrame;
        logic full;
        logic empty;
        logic shockDetected;
        logic fill;
    } fifo_status_t;

    typedef struct packed {
        logic              rowStrobe_b;
        logic              colStrobe_b;
        logic              writeEnable_b;
        logic              outputEnable_b;
        logic              dataOe_b;
        logic [ADDR_W-1:0] addr;
        logic [3:0]        data;
    } dram_ctl_t;

    localparam dram_ctl_t DRAM_IDLE = '{rowStrobe_b: 1'b1, colStrobe_b: 1'b1,
        writeEnable_b: 1'b1, outputEnable_b: 1'b1, dataOe_b: 1'b1,
        addr: 10'h000, data: 4'h0};

    typedef enum logic [1:0] {
        OP_IDLE = 2'b00,
        OP_ROW  = 2'b01,
        OP_COL  = 2'b11,
        OP_END  = 2'b10
    } op_t;
endpackage
`default_nettype wire

// ==== design/shock_audio_fifo_status_ctrl.sv ====
`default_nettype none

module sample_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output var  logic             inReady,
    output logic      [WIDTH-1:0] outData,
    output var  logic             outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrIdx;
    logic [AW-1:0]    rdIdx;
    logic [AW:0]      level;
    logic [AW:0]      next_level;
    logic             push;
    logic             pop;

    assign push    = inValid & inReady;
    assign pop     = outValid & outReady;
    assign outData = mem[rdIdx];

    always_comb begin
        next_level = level;
        if (push && !pop) begin
            next_level = level + (AW+1)'(1);
        end else if (pop && !push) begin
            next_level = level - (AW+1)'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrIdx] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wrIdx    <= '0;
            rdIdx    <= '0;
            level    <= '0;
            inReady  <= 1'b0;
            outValid <= 1'b0;
        end else begin
            if (push) wrIdx <= wrIdx + AW'(1);
            if (pop) rdIdx <= rdIdx + AW'(1);
            level    <= next_level;
            inReady  <= next_level != (AW+1)'(DEPTH);
            outValid <= next_level != '0;
        end
    end
endmodule

module shock_audio_fifo_status_ctrl
    import shock_fifo_pkg::*;
#(
    parameter int INIT_WAIT = INIT_WAIT_CYCLES
) (
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire logic               serialClockIn,
    input  wire logic               serialLoad,
    input  wire logic               serialDataIn,
    output var  logic               serialDataOut,
    output var  logic               serialDataOe_b,
    input  wire logic               correctionFlagIn,
    input  wire logic               shockEventIn,
    input  wire logic               muteRequestIn,
    output var  logic               muteRequestOut,
    input  wire logic               memorySizeSelect,
    input  wire logic               readRateHalve,
    input  wire logic [AUDIO_W-1:0] audioInData,
    input  wire logic               audioInValid,
    output var  logic               audioInReady,
    output var  logic [AUDIO_W-1:0] audioOutData,
    output var  logic               audioOutValid,
    output var  dram_ctl_t          dramCtl,
    input  wire logic [3:0]         dramDataIn,
    output var  logic               outputWordClock,
    output var  logic               outputBitClock,
    output var  logic               synthSubcodeFrame
);
    localparam int WORD_HALF = WORD_CLK_DIV / 2;
    localparam int BIT_HALF  = BIT_CLK_DIV / 2;

    // two-flop sampling of the eight serial and control pin inputs
    logic [7:0] syncA;
    logic [7:0] syncB;
    logic [7:0] syncPrev;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            syncA    <= 8'hc0;
            syncB    <= 8'hc0;
            syncPrev <= 8'hc0;
        end else begin
            syncA    <= {serialClockIn, serialLoad, serialDataIn, correctionFlagIn,
                         shockEventIn, muteRequestIn, memorySizeSelect, readRateHalve};
            syncB    <= syncA;
            syncPrev <= syncB;
        end
    end
    logic sclkRise, loadFall, loadRise, loadLevel, sdaLevel, cflgRise, shockRise;
    logic muteLevel, sizeLarge, halveLevel;
    assign sclkRise   = syncB[7] & ~syncPrev[7];
    assign loadLevel  = syncB[6];
    assign loadFall   = ~syncB[6] & syncPrev[6];
    assign loadRise   = syncB[6] & ~syncPrev[6];
    assign sdaLevel   = syncB[5];
    assign cflgRise   = syncB[4] & ~syncPrev[4];
    assign shockRise  = syncB[3] & ~syncPrev[3];
    assign muteLevel  = syncB[2];
    assign sizeLarge  = syncB[1];
    assign halveLevel = syncB[0];

    // serial link: command write and status read
    logic [7:0]   command;
    logic [7:0]   cmdShift;
    logic [3:0]   wrBits;
    logic         readActive;
    logic [7:0]   statShift;
    logic         statusRead;
    fifo_status_t status;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            command <= CMD_RESET;
        end else if (loadFall && wrBits != 4'h0) begin
            command <= cmdShift;
        end else begin
            command[CMD_FLUSH]  <= 1'b0;
            command[CMD_POS_FB] <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cmdShift       <= 8'h00;
            wrBits         <= 4'h0;
            readActive     <= 1'b0;
            statShift      <= STATUS_RESET;
            serialDataOut  <= 1'b0;
            serialDataOe_b <= 1'b1;
            statusRead     <= 1'b0;
        end else begin
            statusRead <= 1'b0;
            if (loadLevel && sclkRise && !readActive) begin
                cmdShift <= {cmdShift[6:0], sdaLevel};
                if (wrBits != 4'hf) wrBits <= wrBits + 4'h1;
            end
            if (loadFall && wrBits == 4'h0) begin
                readActive     <= 1'b1;
                statShift      <= status;
                serialDataOe_b <= 1'b0;
            end else if (readActive && sclkRise) begin
                serialDataOut <= statShift[7];
                statShift     <= {statShift[6:0], 1'b0};
            end
            if (loadRise) begin
                wrBits         <= 4'h0;
                readActive     <= 1'b0;
                serialDataOe_b <= 1'b1;
                statusRead     <= readActive;
            end
        end
    end

    logic bypass, echo, flushCmd, posFoundCmd, bypassPrev, leaveBypass, flushAll;
    assign bypass      = command[CMD_BYPASS];
    assign echo        = command[CMD_ECHO];
    assign flushCmd    = command[CMD_FLUSH];
    assign posFoundCmd = command[CMD_POS_FB];
    assign leaveBypass = bypassPrev & ~bypass;
    assign flushAll    = flushCmd | leaveBypass;
    always_ff @(posedge clk) begin
        if (!rst_b) bypassPrev <= 1'b1;
        else bypassPrev <= bypass;
    end

    // output clock dividers
    logic [1:0] bitCount;
    logic [7:0] wordCount;
    logic       wordTick;
    assign wordTick = outputWordClock && wordCount == 8'(WORD_HALF - 1);
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bitCount        <= 2'h0;
            wordCount       <= 8'h00;
            outputBitClock  <= 1'b0;
            outputWordClock <= 1'b0;
        end else begin
            bitCount <= bitCount + 2'h1;
            if (bitCount == 2'(BIT_HALF - 1)) begin
                bitCount       <= 2'h0;
                outputBitClock <= ~outputBitClock;
            end
            wordCount <= wordCount + 8'h01;
            if (wordCount == 8'(WORD_HALF - 1)) begin
                wordCount       <= 8'h00;
                outputWordClock <= ~outputWordClock;
            end
        end
    end

    // fifo occupancy from the pointers
    logic [PTR_W-1:0] wrPtr, rdPtr, sizeMask, count;
    logic             atFull, oneWordLeft, haveWord;
    assign sizeMask    = sizeLarge ? LARGE_MASK : SMALL_MASK;
    assign count       = (wrPtr - rdPtr) & sizeMask;
    assign atFull      = count >= ((sizeMask - WORD_NIBBLES) & sizeMask);
    assign oneWordLeft = count <= WORD_NIBBLES;
    assign haveWord    = count >= WORD_NIBBLES;

    // subcode frame tracking
    logic [9:0] frameCount;
    logic       synthEdge, frameMismatch;
    assign synthEdge     = wordTick && frameCount == 10'(SUBCODE_WORDS - 1);
    assign frameMismatch = (cflgRise & ~synthEdge) | (synthEdge & ~cflgRise);
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            frameCount        <= 10'h000;
            synthSubcodeFrame <= 1'b0;
        end else begin
            synthSubcodeFrame <= synthEdge | cflgRise;
            if (cflgRise || synthEdge) frameCount <= 10'h000;
            else if (wordTick) frameCount <= frameCount + 10'h001;
        end
    end

    // status flags: hardware set wins over read clear
    logic fillMode, shockFlag, fullFlag, emptyFlag, frameErr, newFrame, emptyEvent;
    assign emptyEvent = oneWordLeft & ~fillMode & ~emptyFlag & ~bypass;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            frameErr <= 1'b0;
            newFrame <= 1'b0;
        end else begin
            if ((cflgRise && newFrame) || frameMismatch) frameErr <= 1'b1;
            else if (statusRead) frameErr <= 1'b0;
            if (cflgRise) newFrame <= 1'b1;
            else if (statusRead) newFrame <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            fullFlag <= 1'b0;
        end else if (atFull && fillMode) begin
            fullFlag <= 1'b1;
        end else if (statusRead) begin
            fullFlag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            shockFlag <= 1'b0;
        end else if (shockRise || command[CMD_UC_SD]) begin
            shockFlag <= 1'b1;
        end else if (posFoundCmd || flushAll || (emptyEvent && !echo)) begin
            shockFlag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            emptyFlag <= 1'b0;
        end else if (emptyEvent) begin
            emptyFlag <= 1'b1;
        end else if (fillMode) begin
            emptyFlag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            fillMode <= 1'b0;
        end else if ((atFull && fillMode) || shockRise || command[CMD_UC_SD]) begin
            fillMode <= 1'b0;
        end else if (posFoundCmd || flushAll) begin
            fillMode <= 1'b1;
        end else if (emptyEvent && !echo) begin
            fillMode <= 1'b1;
        end
    end

    always_comb begin
        status.levelMsb        = sizeLarge ? count[LARGE_LEVEL_MSB]
                                           : count[SMALL_LEVEL_MSB];
        status.levelNextBit    = sizeLarge ? count[LARGE_LEVEL_MSB-1]
                                           : count[SMALL_LEVEL_MSB-1];
        status.framingError    = frameErr;
        status.newSubcodeFrame = newFrame;
        status.full            = fullFlag;
        status.empty           = emptyFlag;
        status.shockDetected   = shockFlag;
        status.fill            = fillMode;
    end

    // incoming samples are buffered ahead of the dram writer
    logic [AUDIO_W-1:0] fifoData, wrSample;
    logic               fifoValid, wrHave;
    sample_fifo #(.WIDTH(AUDIO_W), .DEPTH(FIFO_DEPTH)) inBuffer (
        .clk      (clk),
        .rst_b    (rst_b),
        .inData   (audioInData),
        .inValid  (audioInValid),
        .inReady  (audioInReady),
        .outData  (fifoData),
        .outValid (fifoValid),
        .outReady (!wrHave)
    );

    // read pacing from the word clock
    logic halfToggle, readPend;
    always_ff @(posedge clk) begin
        if (!rst_b) halfToggle <= 1'b0;
        else if (wordTick) halfToggle <= ~halfToggle;
    end

    // dram access engine
    op_t        opState;
    logic       opRead, opRefresh, initDone, wordDone;
    logic [23:0] initWait;
    logic [3:0] refreshLeft;
    logic [3:0] rdNibble;
    logic       readGo, writeGo, opDone;
    assign readGo  = readPend & haveWord;
    assign writeGo = fillMode & wrHave & ~atFull;
    assign opDone  = opState == OP_END && !opRefresh;

    always_ff @(posedge clk) begin
        if (!rst_b || bypass) begin
            opState     <= OP_IDLE;
            dramCtl     <= DRAM_IDLE;
            opRead      <= 1'b0;
            opRefresh   <= 1'b0;
            initDone    <= 1'b0;
            initWait    <= 24'h000000;
            refreshLeft <= INIT_REFRESH_CYCLES;
            rdNibble    <= 4'h0;
        end else if (!initDone && initWait != 24'(INIT_WAIT)) begin
            initWait <= initWait + 24'h000001;
        end else begin
            unique case (opState)
                OP_IDLE: begin
                    if (!initDone) begin
                        opRefresh           <= 1'b1;
                        dramCtl.addr        <= refreshLeft[3:0] == 4'h0 ? '0
                                               : ADDR_W'(refreshLeft);
                        dramCtl.rowStrobe_b <= 1'b0;
                        opState             <= OP_ROW;
                    end else if (readGo || writeGo) begin
                        opRefresh           <= 1'b0;
                        opRead              <= readGo;
                        dramCtl.addr        <= readGo ? rdPtr[ROW_LSB +: ADDR_W]
                                                      : wrPtr[ROW_LSB +: ADDR_W];
                        dramCtl.rowStrobe_b <= 1'b0;
                        opState             <= OP_ROW;
                    end
                end
                OP_ROW: begin
                    if (opRefresh) begin
                        dramCtl.rowStrobe_b <= 1'b1;
                        opState             <= OP_END;
                    end else begin
                        dramCtl.addr           <= opRead ? rdPtr[ADDR_W-1:0]
                                                         : wrPtr[ADDR_W-1:0];
                        dramCtl.colStrobe_b    <= 1'b0;
                        dramCtl.writeEnable_b  <= opRead;
                        dramCtl.outputEnable_b <= ~opRead;
                        dramCtl.dataOe_b       <= opRead;
                        dramCtl.data           <= wrSample[{wrPtr[1:0], 2'b00} +: NIBBLE_W];
                        opState                <= OP_COL;
                    end
                end
                OP_COL: begin
                    rdNibble <= dramDataIn;
                    dramCtl  <= DRAM_IDLE;
                    opState  <= OP_END;
                end
                OP_END: begin
                    opState <= OP_IDLE;
                    if (opRefresh) begin
                        refreshLeft <= refreshLeft - 4'h1;
                        if (refreshLeft == 4'h1) initDone <= 1'b1;
                    end
                end
            endcase
        end
    end

    // pointers, sample split and reassembly
    logic [11:0] rdAssemble;
    assign wordDone = opDone && opRead && rdPtr[1:0] == 2'h3;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wrPtr         <= '0;
            rdPtr         <= '0;
            wrHave        <= 1'b0;
            wrSample      <= '0;
            rdAssemble    <= 12'h000;
            audioOutData  <= '0;
            audioOutValid <= 1'b0;
        end else begin
            audioOutValid <= wordDone;
            if (flushAll) begin
                wrPtr <= '0;
                rdPtr <= '0;
            end else if (opDone) begin
                if (opRead) begin
                    rdPtr      <= (rdPtr + PTR_W'(1)) & sizeMask;
                    rdAssemble <= {rdNibble, rdAssemble[11:4]};
                    if (wordDone) audioOutData <= {rdNibble, rdAssemble};
                end else begin
                    wrPtr <= (wrPtr + PTR_W'(1)) & sizeMask;
                end
            end
            if (!wrHave && fifoValid) begin
                wrHave   <= 1'b1;
                wrSample <= fifoData;
            end else if (opDone && !opRead && wrPtr[1:0] == 2'h3) begin
                wrHave <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b || flushAll) begin
            readPend <= 1'b0;
        end else if (wordTick && (!halveLevel || halfToggle)) begin
            readPend <= 1'b1;
        end else if (wordDone) begin
            readPend <= 1'b0;
        end
    end

    // mute: pass-through in bypass, generated otherwise
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            muteRequestOut <= 1'b0;
        end else if (bypass) begin
            muteRequestOut <= muteLevel;
        end else if (flushAll) begin
            muteRequestOut <= 1'b0;
        end else if (wordDone && !frameErr) begin
            muteRequestOut <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== verif/dram_model.sv ====
`default_nettype none
module dram_model
    import shock_fifo_pkg::*;
(
    input  wire logic       clk,
    input  wire dram_ctl_t  ctl,
    output var  logic [3:0] q
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0]        mem [logic [19:0]];
    logic [ADDR_W-1:0] row;
    logic [3:0]        last = 4'h0;
    wire logic [19:0]  at = {row, ctl.addr};
    wire logic         rd = !ctl.colStrobe_b && !ctl.outputEnable_b;
    always @(posedge clk) begin
        if (!ctl.rowStrobe_b && ctl.colStrobe_b) begin
            row <= ctl.addr;
        end
        if (!ctl.colStrobe_b && !ctl.writeEnable_b) begin
            mem[at] = ctl.data;
        end
        if (rd) begin
            last <= q;
        end
    end
    // released bus shows the inverse of the last nibble
    assign q = rd ? (mem.exists(at) ? mem[at] : 4'h0) : ~last;
endmodule
`default_nettype wire

// ==== verif/status_ctrl_checker.sv ====
`default_nettype none
module status_ctrl_checker
    import shock_fifo_pkg::*;
(
    input wire logic      clk,
    input wire logic      rst_b,
    input wire logic      serialLoad,
    input wire logic      serialDataOe_b,
    input wire logic      audioOutValid,
    input wire dram_ctl_t dramCtl,
    input wire logic      outputWordClock,
    input wire logic      outputBitClock,
    input wire logic      synthSubcodeFrame
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [8:0] wcCnt;
    logic       wcSeen;
    always_ff @(posedge clk) begin
        if (!rst_b || $rose(outputWordClock)) begin
            wcCnt <= 9'h000;
        end else begin
            wcCnt <= wcCnt + 9'h001;
        end
    end
    always_ff @(posedge clk) begin
        wcSeen <= rst_b && (wcSeen || $rose(outputWordClock));
    end
    sequence colEnd;
        !dramCtl.rowStrobe_b ##1 (dramCtl.rowStrobe_b && dramCtl.colStrobe_b);
    endsequence
    chk_boot_idle: assert property ($rose(rst_b) |-> dramCtl.rowStrobe_b [*8])
        else $error("dram strobe active during bypass");
    chk_bit_clock: assert property ($rose(outputBitClock) |=>
        !$rose(outputBitClock) [*7] ##1 $rose(outputBitClock)) else $error("bit clock period");
    chk_word_period: assert property ($rose(outputWordClock) && wcSeen |->
        wcCnt == 9'h17f) else $error("word clock period");
    chk_load_release: assert property (serialLoad [*6] |-> serialDataOe_b)
        else $error("data pin driven while load high");
    chk_row_col: assert property ($fell(dramCtl.colStrobe_b) |->
        !$past(dramCtl.rowStrobe_b) ##0 colEnd) else $error("row column order");
    chk_one_dir: assert property (!dramCtl.colStrobe_b |->
        dramCtl.writeEnable_b != dramCtl.outputEnable_b) else $error("column cycle direction");
    chk_word_pulse: assert property (audioOutValid |=> !audioOutValid [*8])
        else $error("output word spacing");
    chk_sync_pulse: assert property (synthSubcodeFrame |=> !synthSubcodeFrame)
        else $error("subcode pulse width");
endmodule
bind shock_audio_fifo_status_ctrl status_ctrl_checker chk_u (.clk(clk), .rst_b(rst_b),
    .serialLoad(serialLoad), .serialDataOe_b(serialDataOe_b), .audioOutValid(audioOutValid),
    .dramCtl(dramCtl), .outputWordClock(outputWordClock), .outputBitClock(outputBitClock),
    .synthSubcodeFrame(synthSubcodeFrame));
`default_nettype wire

// ==== verif/testbench.sv ====
`default_nettype none
module testbench
    import shock_fifo_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 0, rst_b = 0, sclk = 1, load = 1, tbSda = 1, flag = 0, shock = 0;
    logic        muteIn = 0, inValid = 0, gotOut = 0;
    logic [15:0] inData = 16'h0000, outData, firstOut;
    logic        sdaOut, sdaOe_b, muteOut, inReady, outValid;
    logic [3:0]  dq;
    logic [7:0]  st;
    dram_ctl_t   ctl;
    int          badCount = 0, numChecks = 0;
    wire logic   sda = sdaOe_b ? tbSda : sdaOut;
    always #4 clk = ~clk;
    shock_audio_fifo_status_ctrl #(.INIT_WAIT(16)) dut_u (.clk(clk), .rst_b(rst_b),
        .serialClockIn(sclk), .serialLoad(load), .serialDataIn(sda), .serialDataOut(sdaOut),
        .serialDataOe_b(sdaOe_b), .correctionFlagIn(flag), .shockEventIn(shock),
        .muteRequestIn(muteIn), .muteRequestOut(muteOut), .memorySizeSelect(1'b0),
        .readRateHalve(1'b0), .audioInData(inData), .audioInValid(inValid),
        .audioInReady(inReady), .audioOutData(outData), .audioOutValid(outValid),
        .dramCtl(ctl), .dramDataIn(dq), .outputWordClock(), .outputBitClock(),
        .synthSubcodeFrame());
    dram_model mem_u (.clk(clk), .ctl(ctl), .q(dq));
    always @(posedge clk) begin
        if (outValid && !gotOut) begin
            firstOut <= outData;
            gotOut   <= 1'b1;
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
        numChecks++;
        if (got !== exp) begin
            badCount++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic rdStatus();
        load = 0;
        tick(5);
        for (int i = 7; i >= 0; i--) begin
            sclk = 0;
            tick(5);
            sclk = 1;
            tick(5);
            st[i] = sda;
        end
        load = 1;
        tick(5);
    endtask
    task automatic wrCmd(input logic [7:0] w);
        for (int i = 7; i >= 0; i--) begin
            sclk = 0;
            tbSda = w[i];
            tick(5);
            sclk = 1;
            tick(5);
        end
        load = 0;
        tick(5);
        load = 1;
        tick(5);
    endtask
    task automatic testReset();
        muteIn = 1;
        tick(4);
        cmp("mute out", 16'h0001, 16'(muteOut));
        muteIn = 0;
        tick(4);
        cmp("mute out", 16'h0000, 16'(muteOut));
        rdStatus();
        cmp("status", 16'(STATUS_RESET), 16'(st));
        $display("reset test done");
    endtask
    task automatic testSubcode();
        repeat (2) begin
            flag = 1;
            tick(4);
            flag = 0;
            tick(40);
        end
        rdStatus();
        cmp("frame bits", 16'h0030, 16'(st & 8'h30));
        rdStatus();
        cmp("frame bits", 16'h0000, 16'(st & 8'h30));
        $display("subcode test done");
    endtask
    task automatic testRun();
        int n;
        muteIn = 1;
        wrCmd(8'h00);
        tick(8);
        cmp("mute out", 16'h0000, 16'(muteOut));
        tick(60);
        for (int k = 0; k < 4; k++) begin
            inData = 16'ha5c3 + 16'(k);
            inValid = 1;
            n = 0;
            while (!inReady && n < 50) begin
                tick(1);
                n++;
            end
            cmp("in ready", 16'h0001, 16'(inReady));
            tick(1);
        end
        inValid = 0;
        n = 0;
        while (!gotOut && n < 2000) begin
            tick(1);
            n++;
        end
        cmp("first word", 16'ha5c3, firstOut);
        tick(10);
        cmp("mute out", 16'h0001, 16'(muteOut));
        rdStatus();
        cmp("fill bit", 16'h0001, 16'(st & 8'h01));
        shock = 1;
        tick(8);
        rdStatus();
        cmp("shock bits", 16'h0002, 16'(st & 8'h03));
        shock = 0;
        tick(1000);
        rdStatus();
        cmp("drain bits", 16'h0001, 16'(st & 8'h07));
        $display("run test done");
    endtask
    task automatic completeRun();
        $display("checks %0d mismatches %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // tests need well under 20000 cycles
    initial begin
        #200000;
        badCount++;
        completeRun();
    end
    initial begin
        tick(5);
        rst_b = 1;
        tick(2);
        testReset();
        testSubcode();
        testRun();
        completeRun();
    end
endmodule
`default_nettype wire
